// file: logic/timer8_defines.svh
/*
  Constants for the 8-bit pulse timer channel: register offsets, field
  positions, reset values and mode codes.
  Assumes inclusion by bare name from design files under logic/.
*/
// Contract
// - buffer_enable 0 disables, 1 enables double buffer
// - buffered running write lands only in buffer
// - even PWM overflow: irq and buffer copy
// - buffered duty read returns buffer value
// - buffered stopped write updates both registers
// - unbuffered write takes effect immediately
// - duty below count waits for overflow match
// - duty equal count matches right after write; here it waits for the next overflow match
// - clock_select picks gear or low-speed divided clock
// - mode register writes ignored while running
// - run bit starts up counter per source tick
// - idle output equals initial_level bit
// - PPG duty match toggles output away from idle
// - PPG cycle match restores idle, raises irq
// - clearing run stops, zeroes counter, idles output
// - output_and_enable ANDs with sibling output
// - PWM toggles on low 7 bits equal duty
// - extra pulse bit lengthens even pulses by one
// - PWM overflow at 128 clears, toggles back
`ifndef TIMER8_DEFINES_SVH
`define TIMER8_DEFINES_SVH

// register byte offsets
`define OFF_DUTY 4'h0
`define OFF_CYCLE 4'h4
`define OFF_MODE 4'h8
`define OFF_PAIR 4'hC
`define OFF_SYS 5'h10
`define ADDR_W 5

// mode register fields
`define MODE_CLK_LSB 0
`define MODE_CLK_MSB 2
`define MODE_OPM_LSB 4
`define MODE_OPM_MSB 5
`define MODE_EXT_BIT 3
`define MODE_INIT_BIT 6
`define MODE_DBE_BIT 7
`define MODE_RESET 8'h00

// pair and system control fields
`define PAIR_RUN_BIT 0
`define PAIR_CAS_BIT 1
`define PAIR_AND_BIT 2
`define SYS_LOW_BIT 0
`define SYS_SLOW_BIT 1

`define DUTY_RESET 8'hFF
`define CYCLE_RESET 8'hFF
`define CNT_ZERO 8'h00
`define PWM_WRAP 8'h80
`define ONE8 8'h01

// operating mode codes
`define OPM_PWM 2'h2
`define OPM_PPG 2'h3

`endif

// file: logic/timer8_pkg.sv
/*
  Types for the 8-bit pulse timer channel.
  Assumes the defines header is compiled alongside.
*/
package timer8_pkg;
  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_PWM = 3'b010,
    ST_PPG = 3'b100
  } run_state_e;
  typedef logic [7:0] byte_t;
endpackage

// file: logic/clock_prescaler.sv
/*
  Source-clock prescaler: turns the gear clock and a low-speed tick into
  one-cycle tick enables, picked by clock_select.
  Assumes low_tick is already synchronous one-cycle pulses on aclk.
*/
`timescale 1ns/1ps
`default_nettype none
`include "timer8_defines.svh"
module clock_prescaler
  import timer8_pkg::*;
(
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // control
  input wire logic enable,
  input wire logic [2:0] clock_select,
  input wire logic low_clock_option,
  input wire logic slow_mode,
  input wire logic low_tick,
  // tick out
  output logic tick
);
  logic [10:0] gear_reg;
  logic [3:0] low_reg;
  logic [11:0] gear_carry;
  logic [4:0] low_carry;
  logic use_low;

  // a divider bit rising means 2^(k+1) gear cycles elapsed
  assign gear_carry = {1'b1, ~gear_reg & (gear_reg + 11'h001)} ;
  assign low_carry = {1'b1, ~low_reg & (low_reg + 4'h1)};
  assign use_low = low_clock_option | slow_mode;

  always_ff @(posedge aclk) begin
    if (!aresetn || !enable) begin
      gear_reg <= 11'h000;
      low_reg <= 4'h0;
    end else begin
      gear_reg <= gear_reg + 11'h001;
      if (low_tick)
        low_reg <= low_reg + 4'h1;
    end
  end

  always_comb begin
    tick = 1'b0;
    unique case (clock_select)
      3'h0: tick = use_low ? (low_tick & low_carry[3]) : gear_carry[10];
      3'h1: tick = use_low ? (low_tick & low_carry[2]) : gear_carry[9];
      3'h2: tick = gear_carry[7];
      3'h3: tick = gear_carry[5];
      3'h4: tick = gear_carry[3];
      3'h5: tick = gear_carry[1];
      3'h6: tick = gear_carry[0];
      3'h7: tick = use_low ? (low_tick & low_carry[1]) : 1'b1;
    endcase
  end
endmodule
`default_nettype wire

// file: logic/bit_sync.sv
/*
  Two-flop synchroniser for one level from outside the aclk domain.
  Assumes nothing reads the first stage.
*/
`timescale 1ns/1ps
`default_nettype none
module bit_sync (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // data
  input wire logic d,
  output logic q
);
  logic meta_reg;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      meta_reg <= 1'b0;
      q <= 1'b0;
    end else begin
      meta_reg <= d;
      q <= meta_reg;
    end
  end
endmodule
`default_nettype wire

// file: logic/timer8_pwm_ppg_output.sv
/*
  One 8-bit timer channel in 7-bit PWM or PPG output mode, with duty
  double buffer, initial level, AND with sibling output and period irq.
  Assumes an AXI4-Lite master on aclk; sibling output and low-speed clock
  arrive from outside and are synchronised here.
*/
`timescale 1ns/1ps
`default_nettype none
`include "timer8_defines.svh"
module timer8_pwm_ppg_output
  import timer8_pkg::*;
(
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // axi4-lite write address
  input wire logic [`ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  // axi4-lite write data
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  // axi4-lite write response
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // axi4-lite read
  input wire logic [`ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // outside world
  input wire logic low_speed_clock,
  input wire logic sibling_pulse,
  // outputs
  output logic pulse_out_pin,
  output logic pulse_level,
  output logic timer_irq
);
  // =====================================================
  // registers
  byte_t duty_buf_reg, duty_compare_reg, cycle_buf_reg, cycle_compare_reg;
  byte_t channel_mode_reg, count_reg, count_next;
  logic [2:0] pair_control_reg;
  logic [1:0] system_control_reg;
  logic level_reg, level_next, irq_reg, irq_next, ovf_odd_reg, ovf_odd_next;
  logic pulse_odd_reg, pulse_odd_next, ext_pending_reg, ext_pending_next;
  logic duty_wr_pend_reg;
  run_state_e state_reg, state_next;

  // =====================================================
  // bus slave
  logic aw_held_reg, w_held_reg;
  logic [`ADDR_W-1:0] aw_addr_reg;
  logic [31:0] w_data_reg;
  logic [3:0] w_strb_reg;
  logic wr_go, rd_go, wr_ok, rd_ok;
  logic wr_duty, wr_cycle, wr_mode, wr_pair, wr_sys;
  logic [31:0] rd_word;

  assign s_axi_awready = !aw_held_reg && !s_axi_bvalid;
  assign s_axi_wready = !w_held_reg && !s_axi_bvalid;
  assign wr_go = aw_held_reg && w_held_reg && !s_axi_bvalid;
  assign wr_ok = wr_go && w_strb_reg[0];
  assign wr_duty = wr_ok && aw_addr_reg == {1'b0, `OFF_DUTY};
  assign wr_cycle = wr_ok && aw_addr_reg == {1'b0, `OFF_CYCLE};
  assign wr_mode = wr_ok && aw_addr_reg == {1'b0, `OFF_MODE};
  assign wr_pair = wr_ok && aw_addr_reg == {1'b0, `OFF_PAIR};
  assign wr_sys = wr_ok && aw_addr_reg == `OFF_SYS;
  assign s_axi_arready = !s_axi_rvalid;
  assign rd_go = s_axi_arvalid && s_axi_arready;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held_reg <= 1'b0;
      w_held_reg <= 1'b0;
      aw_addr_reg <= '0;
      w_data_reg <= 32'h0000_0000;
      w_strb_reg <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= 2'h0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_held_reg <= 1'b1;
        aw_addr_reg <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_held_reg <= 1'b1;
        w_data_reg <= s_axi_wdata;
        w_strb_reg <= s_axi_wstrb;
      end
      if (wr_go) begin
        aw_held_reg <= 1'b0;
        w_held_reg <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= (wr_duty | wr_cycle | wr_mode | wr_pair | wr_sys
                        | !w_strb_reg[0]) ? 2'h0 : 2'h2;
      end else if (s_axi_bready)
        s_axi_bvalid <= 1'b0;
    end
  end

  always_comb begin
    rd_ok = 1'b1;
    rd_word = 32'h0000_0000;
    unique case (s_axi_araddr)
      {1'b0, `OFF_DUTY}: rd_word[7:0] = channel_mode_reg[`MODE_DBE_BIT] ?
                                        duty_buf_reg : duty_compare_reg;
      {1'b0, `OFF_CYCLE}: rd_word[7:0] = channel_mode_reg[`MODE_DBE_BIT] ?
                                         cycle_buf_reg : cycle_compare_reg;
      {1'b0, `OFF_MODE}: rd_word[7:0] = channel_mode_reg;
      {1'b0, `OFF_PAIR}: rd_word[2:0] = pair_control_reg;
      `OFF_SYS: rd_word[1:0] = system_control_reg;
      default: rd_ok = 1'b0;
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= 2'h0;
    end else if (rd_go) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= rd_word;
      s_axi_rresp <= rd_ok ? 2'h0 : 2'h2;
    end else if (s_axi_rready)
      s_axi_rvalid <= 1'b0;
  end

  // =====================================================
  // control decode
  logic running, dbe, init_lvl, tick, low_lvl, low_lvl_d, low_tick, sib;
  logic [1:0] opm;
  logic pwm_mode, ppg_mode;

  assign running = pair_control_reg[`PAIR_RUN_BIT];
  assign dbe = channel_mode_reg[`MODE_DBE_BIT];
  assign init_lvl = channel_mode_reg[`MODE_INIT_BIT];
  assign opm = channel_mode_reg[`MODE_OPM_MSB:`MODE_OPM_LSB];
  assign pwm_mode = opm == `OPM_PWM;
  assign ppg_mode = opm == `OPM_PPG;
  assign low_tick = low_lvl & ~low_lvl_d;

  bit_sync u_low_sync (
    .aclk(aclk),
    .aresetn(aresetn),
    .d(low_speed_clock),
    .q(low_lvl)
  );

  bit_sync u_sib_sync (
    .aclk(aclk),
    .aresetn(aresetn),
    .d(sibling_pulse),
    .q(sib)
  );

  clock_prescaler u_presc (
    .aclk(aclk),
    .aresetn(aresetn),
    .enable(running),
    .clock_select(channel_mode_reg[`MODE_CLK_MSB:`MODE_CLK_LSB]),
    .low_clock_option(system_control_reg[`SYS_LOW_BIT]),
    .slow_mode(system_control_reg[`SYS_SLOW_BIT]),
    .low_tick(low_tick),
    .tick(tick)
  );

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      channel_mode_reg <= `MODE_RESET;
      pair_control_reg <= 3'h0;
      system_control_reg <= 2'h0;
      duty_buf_reg <= `DUTY_RESET;
      cycle_buf_reg <= `CYCLE_RESET;
      low_lvl_d <= 1'b0;
    end else begin
      low_lvl_d <= low_lvl;
      if (wr_mode && !running)
        channel_mode_reg <= w_data_reg[7:0];
      if (wr_pair)
        pair_control_reg <= w_data_reg[2:0];
      if (wr_sys)
        system_control_reg <= w_data_reg[1:0];
      if (wr_duty)
        duty_buf_reg <= w_data_reg[7:0];
      if (wr_cycle)
        cycle_buf_reg <= w_data_reg[7:0];
    end
  end

  // =====================================================
  // counter and compare
  logic [6:0] pwm_target;
  logic [7:0] count_plus;
  logic pwm_hit, ppg_duty_hit, ppg_cycle_hit, pwm_wrap, even_wrap;
  logic duty_hit_now, load_duty, load_cycle;

  // lengthen every second duty pulse by one count
  assign pwm_target = duty_compare_reg[7:1] +
                      {6'h00, duty_compare_reg[0] & pulse_odd_reg};
  // matches fire as the count reaches the value, so a period of n is n ticks
  assign count_plus = count_reg + `ONE8;
  // compare is against the next count, so a write equal to the current count waits for the wrap
  assign pwm_hit = count_plus[6:0] == pwm_target;
  assign ppg_duty_hit = count_plus == duty_compare_reg;
  assign ppg_cycle_hit = count_plus == cycle_compare_reg;
  assign pwm_wrap = count_reg == (`PWM_WRAP - `ONE8);
  assign even_wrap = pwm_wrap && ovf_odd_reg;
  // a hit is taken only when the count arrives, never skipped back
  assign duty_hit_now = pwm_mode ? pwm_hit : ppg_duty_hit;
  assign load_duty = dbe ? (wr_duty && !running) || (tick && state_reg != ST_IDLE
                     && (pwm_mode ? even_wrap : ppg_cycle_hit)) : wr_duty;
  assign load_cycle = dbe ? (wr_cycle && !running) ||
                      (tick && state_reg == ST_PPG && ppg_cycle_hit) : wr_cycle;

  always_comb begin
    state_next = state_reg;
    count_next = count_reg;
    level_next = level_reg;
    irq_next = 1'b0;
    ovf_odd_next = ovf_odd_reg;
    pulse_odd_next = pulse_odd_reg;
    ext_pending_next = ext_pending_reg;
    unique case (state_reg)
      ST_IDLE: begin
        count_next = `CNT_ZERO;
        level_next = init_lvl;
        ovf_odd_next = 1'b0;
        pulse_odd_next = 1'b0;
        if (running)
          state_next = pwm_mode ? ST_PWM : ST_PPG;
      end
      ST_PWM: begin
        if (!running) begin
          state_next = ST_IDLE;
          count_next = `CNT_ZERO;
          level_next = init_lvl;
        end else if (tick) begin
          count_next = pwm_wrap ? `CNT_ZERO : count_reg + `ONE8;
          if (pwm_hit && level_reg == init_lvl) begin
            level_next = ~init_lvl;
            pulse_odd_next = ~pulse_odd_reg;
          end
          if (pwm_wrap) begin
            level_next = init_lvl;
            ovf_odd_next = ~ovf_odd_reg;
            irq_next = ovf_odd_reg;
          end
        end
      end
      ST_PPG: begin
        if (!running) begin
          state_next = ST_IDLE;
          count_next = `CNT_ZERO;
          level_next = init_lvl;
        end else if (tick) begin
          count_next = count_reg + `ONE8;
          if (ppg_duty_hit)
            level_next = ~init_lvl;
          if (ppg_cycle_hit) begin
            count_next = `CNT_ZERO;
            level_next = init_lvl;
            irq_next = 1'b1;
          end
        end
      end
      default: state_next = ST_IDLE;
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state_reg <= ST_IDLE;
      count_reg <= `CNT_ZERO;
      level_reg <= 1'b0;
      irq_reg <= 1'b0;
      ovf_odd_reg <= 1'b0;
      pulse_odd_reg <= 1'b0;
      ext_pending_reg <= 1'b0;
      duty_wr_pend_reg <= 1'b0;
      duty_compare_reg <= `DUTY_RESET;
      cycle_compare_reg <= `CYCLE_RESET;
      pulse_out_pin <= 1'b0;
    end else begin
      state_reg <= state_next;
      count_reg <= count_next;
      level_reg <= level_next;
      irq_reg <= irq_next;
      ovf_odd_reg <= ovf_odd_next;
      pulse_odd_reg <= pulse_odd_next;
      ext_pending_reg <= ext_pending_next;
      duty_wr_pend_reg <= duty_hit_now;
      if (load_duty)
        duty_compare_reg <= (wr_duty && (!dbe || !running)) ? w_data_reg[7:0]
                                                             : duty_buf_reg;
      if (load_cycle)
        cycle_compare_reg <= (wr_cycle && (!dbe || !running)) ? w_data_reg[7:0]
                                                              : cycle_buf_reg;
      pulse_out_pin <= pair_control_reg[`PAIR_AND_BIT] ? (level_next & sib)
                                                       : level_next;
    end
  end

  assign pulse_level = level_reg;
  assign timer_irq = irq_reg;
endmodule
`default_nettype wire

// file: tb/timer8_properties.sv
/*
  Checker for the pulse timer channel: bus handshakes and output pins.
  Assumes it is bound to timer8_pwm_ppg_output and sees only its ports.
*/
`timescale 1ns/1ps
`default_nettype none
module timer8_checker (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // register bus
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [31:0] s_axi_rdata,
  // outputs
  input wire logic pulse_out_pin,
  input wire logic pulse_level,
  input wire logic timer_irq
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // ==========================================================
  // bus
  wr_answer_a: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
    |-> ##2 s_axi_bvalid) else $error("write response missing");
  wr_single_a: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
    else $error("write response repeated");
  wr_busy_a: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write accepted while response pending");
  rd_answer_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read data missing");
  rd_single_a: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
    else $error("read data repeated");
  rd_upper_a: assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h000000)
    else $error("upper read bits not zero");
  // ==========================================================
  // outputs
  pin_gate_a: assert property (pulse_out_pin |-> pulse_level)
    else $error("pin high without own pulse");
  irq_pulse_a: assert property (timer_irq |=> !timer_irq)
    else $error("interrupt longer than one cycle");
endmodule
bind timer8_pwm_ppg_output timer8_checker chk_u (.aclk, .aresetn, .s_axi_awvalid,
  .s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid, .s_axi_bready,
  .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid, .s_axi_rready, .s_axi_rdata,
  .pulse_out_pin, .pulse_level, .timer_irq);
`default_nettype wire

// file: tb/testbench.sv
/*
  Self-checking bench for the pulse timer channel, register bus driven.
  Assumes the defines header on the include path; low-speed clock unused.
*/
`timescale 1ns/1ps
`default_nettype none
`include "timer8_defines.svh"
module testbench;
  logic aclk, aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready;
  logic [`ADDR_W-1:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [3:0] s_axi_wstrb;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic low_speed_clock, sibling_pulse, pulse_out_pin, pulse_level, timer_irq;
  int fails, total_checks, per, hi, pn;
  int divs[8] = '{2048, 1024, 256, 64, 16, 4, 2, 1};

  timer8_pwm_ppg_output dut_u (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
    .s_axi_rvalid, .s_axi_rready, .low_speed_clock, .sibling_pulse, .pulse_out_pin,
    .pulse_level, .timer_irq);

  initial begin
    aclk = 1'h0;
    forever #2.5 aclk = ~aclk;
  end

  // ==========================================================
  // tasks
  task automatic stop_test();
    $display("checks %0d mismatches %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    total_checks++;
    if (g !== e) begin
      $display("ERROR %s expected %h seen %h", n, e, g);
      fails++;
    end
  endtask

  // ready is combinational from state, so its value at the falling edge holds at the next rise
  task automatic wr(input logic [4:0] a, input logic [31:0] d, input logic [1:0] er);
    logic pa, pw, ha, hw;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'h1;
    s_axi_wvalid <= 1'h1;
    s_axi_bready <= 1'h1;
    pa = 1'h1;
    pw = 1'h1;
    while (pa || pw) begin
      @(negedge aclk);
      ha = pa && s_axi_awready;
      hw = pw && s_axi_wready;
      @(posedge aclk);
      if (ha) s_axi_awvalid <= 1'h0;
      if (hw) s_axi_wvalid <= 1'h0;
      pa = pa && !ha;
      pw = pw && !hw;
    end
    do @(negedge aclk); while (s_axi_bvalid !== 1'h1);
    chk("bresp", er, s_axi_bresp);
    @(posedge aclk);
    s_axi_bready <= 1'h0;
  endtask

  task automatic rdc(input logic [4:0] a, input logic [31:0] e, input logic [1:0] er);
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'h1;
    s_axi_rready <= 1'h1;
    do @(negedge aclk); while (s_axi_arready !== 1'h1);
    @(posedge aclk);
    s_axi_arvalid <= 1'h0;
    do @(negedge aclk); while (s_axi_rvalid !== 1'h1);
    chk("rresp", er, s_axi_rresp);
    if (er == 2'h0) chk("rdata", e, s_axi_rdata);
    @(posedge aclk);
    s_axi_rready <= 1'h0;
  endtask

  // one full interrupt period: its length, own high cycles and pin high cycles
  task automatic meas();
    do @(negedge aclk); while (timer_irq !== 1'h1);
    per = 0;
    hi = 0;
    pn = 0;
    do begin
      @(negedge aclk);
      per++;
      hi += pulse_level;
      pn += pulse_out_pin;
    end while (timer_irq !== 1'h1);
  endtask

  task automatic start(input logic [7:0] m, input logic [7:0] d, input logic [7:0] c);
    wr(`OFF_PAIR, 32'h0, 2'h0);
    wr(`OFF_MODE, {24'h0, m}, 2'h0);
    wr(`OFF_DUTY, {24'h0, d}, 2'h0);
    wr(`OFF_CYCLE, {24'h0, c}, 2'h0);
    wr(`OFF_PAIR, 32'h1, 2'h0);
  endtask

  // ==========================================================
  // watchdog, sized well beyond the slowest clock-select pass
  initial begin
    #(100000 * 5);
    fails++;
    stop_test();
  end

  // ==========================================================
  // tests
  initial begin
    aresetn = 1'h0;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h00;
    s_axi_awaddr = 5'h00;
    s_axi_araddr = 5'h00;
    s_axi_wdata = 32'h0;
    s_axi_wstrb = 4'hF;
    low_speed_clock = 1'h0;
    sibling_pulse = 1'h1;
    fails = 0;
    total_checks = 0;
    repeat (4) @(posedge aclk);
    aresetn <= 1'h1;
    rdc(`OFF_DUTY, 32'hFF, 2'h0);
    rdc(`OFF_CYCLE, 32'hFF, 2'h0);
    rdc(`OFF_MODE, 32'h00, 2'h0);
    rdc(5'h14, 32'h0, 2'h2);
    wr(5'h14, 32'h1, 2'h2);
    s_axi_wstrb <= 4'h0;
    wr(`OFF_DUTY, 32'h11, 2'h0);
    s_axi_wstrb <= 4'hF;
    rdc(`OFF_DUTY, 32'hFF, 2'h0);
    wr(`OFF_MODE, 32'h77, 2'h0);
    repeat (3) @(posedge aclk);
    chk("idle pin", 32'h1, pulse_out_pin);
    $display("test registers done");
    for (int k = 0; k < 8; k++) begin
      start(8'h30 | 8'(k), 8'h02, 8'h06);
      meas();
      chk("ppg period", 6 * divs[k], per);
      chk("ppg high", 4 * divs[k], hi);
    end
    start(8'h77, 8'h02, 8'h06);
    meas();
    chk("ppg high init1", 32'h2, hi);
    wr(`OFF_MODE, 32'h00, 2'h0);
    rdc(`OFF_MODE, 32'h77, 2'h0);
    wr(`OFF_PAIR, 32'h0, 2'h0);
    repeat (3) @(posedge aclk);
    chk("stopped pin", 32'h1, pulse_out_pin);
    start(8'h37, 8'h02, 8'h06);
    sibling_pulse <= 1'h0;
    wr(`OFF_PAIR, 32'h5, 2'h0);
    meas();
    chk("and pin low", 32'h0, pn);
    sibling_pulse <= 1'h1;
    meas();
    chk("and pin high", 32'h4, pn);
    $display("test ppg done");
    start(8'hA7, 8'h20, 8'h06);
    meas();
    chk("pwm period", 32'd256, per);
    chk("pwm high", 32'd224, hi);
    wr(`OFF_DUTY, 32'h41, 2'h0);
    rdc(`OFF_DUTY, 32'h41, 2'h0);
    meas();
    chk("pwm buffered", 32'd191, hi);
    start(8'h27, 8'h20, 8'h06);
    wr(`OFF_DUTY, 32'h60, 2'h0);
    meas();
    chk("pwm direct", 32'd160, hi);
    $display("test pwm done");
    stop_test();
  end
endmodule
`default_nettype wire
